// ==== src/rsa_pkg.sv ====
package rsa_pkg;

	// ==========================================================
	// Control word fields for the range total
	localparam int CW_SKIP_HI_BIT = 12;
	localparam int CW_BYTE_BIT = 13;
	localparam int CW_BIN_BIT = 14;
	localparam int CW_SIGNED_BIT = 15;
	localparam logic [15:0] COUNT_MIN = 16'h0001;

	// ==========================================================
	// Arithmetic process codes and table header fields
	localparam logic [15:0] TRIG_SIN = 16'h0000;
	localparam logic [15:0] TRIG_COS = 16'h0001;
	localparam logic [15:0] ANGLE_MAX = 16'h0384;
	localparam int HDR_MIRROR_BIT = 13;
	localparam int HDR_OUT_BIN_BIT = 14;
	localparam int HDR_IN_BIN_BIT = 15;
	localparam logic [2:0] STEP_SRC = 3'h0;
	localparam logic [2:0] STEP_HDR = 3'h1;
	localparam logic [2:0] STEP_XMAX = 3'h2;
	localparam logic [2:0] STEP_Y0 = 3'h3;
	localparam logic [2:0] STEP_XK = 3'h4;
	localparam logic [2:0] STEP_YK = 3'h5;

	// ==========================================================
	// Iterative engines: rotation in Q4.20, radians per tenth in Q.28
	localparam logic [5:0] CORDIC_ITER = 6'h10;
	localparam logic [5:0] DIV_ITER = 6'h20;
	localparam logic signed [23:0] CORDIC_GAIN = 24'sh09b74f;
	localparam logic [31:0] RAD_PER_TENTH = 32'h0007261d;
	localparam logic signed [23:0] FRAC_ONE = 24'sh100000;
	localparam logic signed [23:0] TRUNC_BIAS = 24'sh000018;

	function automatic logic signed [23:0] cordic_atan(input logic [5:0] i);
		case (i)
			6'h00: cordic_atan = 24'sh0c90fe;
			6'h01: cordic_atan = 24'sh076b1a;
			6'h02: cordic_atan = 24'sh03eb6f;
			6'h03: cordic_atan = 24'sh01fd5c;
			6'h04: cordic_atan = 24'sh00ffab;
			6'h05: cordic_atan = 24'sh007ff5;
			6'h06: cordic_atan = 24'sh003fff;
			6'h07: cordic_atan = 24'sh002000;
			6'h08: cordic_atan = 24'sh001000;
			6'h09: cordic_atan = 24'sh000800;
			6'h0a: cordic_atan = 24'sh000400;
			6'h0b: cordic_atan = 24'sh000200;
			6'h0c: cordic_atan = 24'sh000100;
			6'h0d: cordic_atan = 24'sh000080;
			6'h0e: cordic_atan = 24'sh000040;
			6'h0f: cordic_atan = 24'sh000020;
			default: cordic_atan = 24'sh000000;
		endcase
	endfunction

	// ==========================================================
	// Sequencer register map (byte offsets) and data memory
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_CWORD = 8'h04;
	localparam logic [7:0] REG_SRC = 8'h08;
	localparam logic [7:0] REG_DST = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_MADDR = 8'h14;
	localparam logic [7:0] REG_MDATA = 8'h18;
	localparam int MEM_AW = 10;
	localparam logic [15:0] MEM_WORDS = 16'h0400;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_READ = 4'h1,
		ST_WAIT = 4'h2,
		ST_USE = 4'h3,
		ST_CORDIC = 4'h4,
		ST_DIVIDE = 4'h5,
		ST_WRITE = 4'h6,
		ST_WWAIT = 4'h7,
		ST_DONE = 4'h8
	} rsa_state_type;

endpackage

// ==== src/rsa_link_if.sv ====
interface rsa_link_if;
	logic req;
	logic op_apr;
	logic exec_cond;
	logic ctrl_const;
	logic [15:0] ctrl_word;
	logic [15:0] src_addr;
	logic [15:0] dst_addr;
	logic busy;
	logic done;
	logic error_flag;
	logic equal_zero_flag;
	logic negative_flag;
	logic mem_req;
	logic mem_we;
	logic [15:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic mem_ack;
	logic mem_err;

	modport unit(input req, input op_apr, input exec_cond, input ctrl_const, input ctrl_word,
		input src_addr, input dst_addr, output busy, output done, output error_flag,
		output equal_zero_flag, output negative_flag, output mem_req, output mem_we,
		output mem_addr, output mem_wdata, input mem_rdata, input mem_ack, input mem_err);

	modport seq(output req, output op_apr, output exec_cond, output ctrl_const, output ctrl_word,
		output src_addr, output dst_addr, input busy, input done, input error_flag,
		input equal_zero_flag, input negative_flag, input mem_req, input mem_we,
		input mem_addr, input mem_wdata, output mem_rdata, output mem_ack, output mem_err);
endinterface

// ==== src/rsa_bcd_add.sv ====
module rsa_bcd_add #(
	parameter int DIG = 8
) (
	input wire logic [4*DIG-1:0] a,
	input wire logic [4*DIG-1:0] b,
	input wire logic cin,
	output logic [4*DIG-1:0] sum,
	output logic cout
);
	logic [DIG:0] c;

	assign c[0] = cin;
	assign cout = c[DIG];

	// ==========================================================
	// One decimal digit per stage, ripple carry
	for (genvar g = 0; g < DIG; g++) begin : g_dig
		wire [4:0] raw = {1'b0, a[4*g +: 4]} + {1'b0, b[4*g +: 4]} + {4'h0, c[g]};
		wire over = raw > 5'h09;
		wire [4:0] fix = raw + 5'h06;
		assign sum[4*g +: 4] = over ? fix[3:0] : raw[3:0];
		assign c[g+1] = over;
	end
endmodule // rsa_bcd_add

// ==== src/rsa_arith_unit.sv ====
// The APB interface to the registers and the register addresses were chosen for this implementation.
module rsa_arith_unit (
	input wire logic CLOCK,
	input wire logic NRST,
	rsa_link_if.unit LINK,
	output logic BUSY
);
	rsa_pkg::rsa_state_type state_q;
	logic busy_q, done_q, er_q, eq_q, neg_q;
	logic req_q, we_q;
	logic [15:0] maddr_q, wdata_q;
	logic op_q, cconst_q, half_q, wr_hi_q, sgn_q;
	logic [15:0] cw_q, dst_q, addr_q, rd_q, cnt_q;
	logic [15:0] x_q, hdr_q, xm_q, px_q, py_q, cx_q, den_q, rem_q, res_q;
	logic [31:0] acc_q, num_q;
	logic [7:0] k_q;
	logic [2:0] step_q;
	logic [5:0] it_q;
	logic signed [23:0] cx_r, cy_r, cz_r;

	// ==========================================================
	// Digit helpers
	function automatic logic is_bcd(input logic [15:0] v);
		is_bcd = (v[15:12] < 4'ha) && (v[11:8] < 4'ha) && (v[7:4] < 4'ha) && (v[3:0] < 4'ha);
	endfunction

	function automatic logic [15:0] bcd2bin(input logic [15:0] v);
		bcd2bin = {12'h000, v[15:12]} * 16'd1000 + {12'h000, v[11:8]} * 16'd100
			+ {12'h000, v[7:4]} * 16'd10 + {12'h000, v[3:0]};
	endfunction

	function automatic logic [15:0] bin2bcd(input logic [15:0] v);
		logic [35:0] s;
		s = {20'h00000, v};
		for (int i = 0; i < 16; i++) begin
			for (int j = 0; j < 5; j++) begin
				if (s[16+4*j +: 4] > 4'h4) s[16+4*j +: 4] = s[16+4*j +: 4] + 4'h3;
			end
			s = {s[34:0], 1'b0};
		end
		bin2bcd = s[31:16];
	endfunction

	// Each step multiplies by ten and peels the integer digit; lower digits drop off
	function automatic logic [15:0] frac2bcd(input logic [19:0] v);
		logic [23:0] t;
		logic [19:0] f;
		f = v;
		frac2bcd = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			t = {1'b0, f, 3'b000} + {3'b000, f, 1'b0};
			frac2bcd = {frac2bcd[11:0], t[23:20]};
			f = t[19:0];
		end
	endfunction

	// ==========================================================
	// Range total datapath
	wire byte_mode = cw_q[rsa_pkg::CW_BYTE_BIT];
	wire bcd_mode = !cw_q[rsa_pkg::CW_BIN_BIT];
	wire signed_mode = cw_q[rsa_pkg::CW_BIN_BIT] && cw_q[rsa_pkg::CW_SIGNED_BIT];
	wire [7:0] byte_sel = half_q ? rd_q[7:0] : rd_q[15:8];
	wire [15:0] item = byte_mode ? {8'h00, byte_sel} : rd_q;
	wire [31:0] item_sx = byte_mode ? {{24{byte_sel[7]}}, byte_sel} : {{16{rd_q[15]}}, rd_q};
	wire [31:0] acc_bin = acc_q + (signed_mode ? item_sx : {16'h0000, item});
	wire [31:0] acc_bcd;
	wire [31:0] acc_next = bcd_mode ? acc_bcd : acc_bin;
	wire item_bad = bcd_mode && !is_bcd(item);
	wire [15:0] cnt_field = {4'h0, LINK.ctrl_word[11:0]};
	wire [15:0] cnt_bin = bcd2bin(cnt_field);
	wire cnt_ok = is_bcd(cnt_field) && (cnt_bin >= rsa_pkg::COUNT_MIN);

	rsa_bcd_add #(.DIG(8)) u_bcd (
		.a(acc_q),
		.b({16'h0000, item}),
		.cin(1'b0),
		.sum(acc_bcd),
		.cout()
	);

	// ==========================================================
	// Arithmetic process datapath
	wire trig_mode = cconst_q;
	wire ctrl_ok = (LINK.ctrl_word == rsa_pkg::TRIG_SIN) || (LINK.ctrl_word == rsa_pkg::TRIG_COS);
	wire [15:0] ang_bin = bcd2bin(rd_q);
	wire ang_ok = is_bcd(rd_q) && (ang_bin <= rsa_pkg::ANGLE_MAX);
	wire [31:0] ang_rad = {16'h0000, ang_bin} * rsa_pkg::RAD_PER_TENTH;
	wire signed [23:0] atan_i = rsa_pkg::cordic_atan(it_q);
	wire signed [23:0] xs = cx_r >>> it_q;
	wire signed [23:0] ys = cy_r >>> it_q;
	// A small bias offsets the rotator's residual error before truncation
	wire signed [23:0] trig_raw = (cw_q[0] ? cx_r : cy_r) + rsa_pkg::TRUNC_BIAS;
	wire [19:0] trig_frac = trig_raw[23] ? 20'h00000 :
		(trig_raw >= rsa_pkg::FRAC_ONE) ? 20'hfffff : trig_raw[19:0];
	wire [15:0] trig_bcd = frac2bcd(trig_frac);
	wire in_bin = rd_q[rsa_pkg::HDR_IN_BIN_BIT];
	wire [15:0] x_conv = in_bin ? x_q : bcd2bin(x_q);
	wire [15:0] x_mirror = (x_q > rd_q) ? 16'h0000 : rd_q - x_q;
	wire signed [16:0] dy = $signed({1'b0, rd_q}) - $signed({1'b0, py_q});
	wire [15:0] dxp = x_q - px_q;
	wire signed [33:0] prod = dy * $signed({1'b0, dxp});
	wire [33:0] prod_abs = prod[33] ? 34'h000000000 - prod : prod;
	wire [16:0] dtrial = {rem_q, num_q[31]};
	wire dfit = dtrial >= {1'b0, den_q};
	wire [16:0] dsub = dtrial - {1'b0, den_q};
	wire [16:0] qv = sgn_q ? 17'h00000 - num_q[16:0] : num_q[16:0];
	wire [15:0] lin_y = py_q + qv[15:0];
	wire out_bin = hdr_q[rsa_pkg::HDR_OUT_BIN_BIT];
	wire [15:0] lin_fmt = out_bin ? lin_y : bin2bcd(lin_y);
	wire [15:0] cy_fmt = out_bin ? rd_q : bin2bcd(rd_q);
	wire last_seg = (k_q == hdr_q[7:0] + 8'h01);
	wire [15:0] wr_word = op_q ? res_q : (wr_hi_q ? acc_q[31:16] : acc_q[15:0]);
	wire [15:0] low_word = op_q ? res_q : acc_q[15:0];
	wire zero_res = op_q ? (res_q == 16'h0000) : (acc_q == 32'h00000000);

	// ==========================================================
	// Sequencer
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state_q <= rsa_pkg::ST_IDLE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			er_q <= 1'b0;
			eq_q <= 1'b0;
			neg_q <= 1'b0;
			req_q <= 1'b0;
			we_q <= 1'b0;
			maddr_q <= rsa_pkg::WORD_RESET;
			wdata_q <= rsa_pkg::WORD_RESET;
		end else begin
			req_q <= 1'b0;
			done_q <= 1'b0;
			case (state_q)
				rsa_pkg::ST_IDLE: begin
					if (LINK.req) begin
						op_q <= LINK.op_apr;
						cconst_q <= LINK.ctrl_const;
						cw_q <= LINK.ctrl_word;
						dst_q <= LINK.dst_addr;
						addr_q <= LINK.src_addr;
						acc_q <= 32'h00000000;
						half_q <= LINK.ctrl_word[rsa_pkg::CW_BYTE_BIT]
							&& LINK.ctrl_word[rsa_pkg::CW_SKIP_HI_BIT];
						cnt_q <= cnt_bin;
						wr_hi_q <= 1'b0;
						step_q <= rsa_pkg::STEP_SRC;
						busy_q <= 1'b1;
						if (!LINK.exec_cond) begin
							state_q <= rsa_pkg::ST_DONE;
						end else begin
							er_q <= 1'b0;
							if ((!LINK.op_apr && !cnt_ok) ||
								(LINK.op_apr && LINK.ctrl_const && !ctrl_ok)) begin
								er_q <= 1'b1;
								state_q <= rsa_pkg::ST_DONE;
							end else begin
								state_q <= rsa_pkg::ST_READ;
							end
						end
					end
				end
				rsa_pkg::ST_READ: begin
					req_q <= 1'b1;
					we_q <= 1'b0;
					maddr_q <= addr_q;
					state_q <= rsa_pkg::ST_WAIT;
				end
				rsa_pkg::ST_WAIT: begin
					if (LINK.mem_ack) begin
						rd_q <= LINK.mem_rdata;
						if (LINK.mem_err) begin
							er_q <= 1'b1;
							state_q <= rsa_pkg::ST_DONE;
						end else begin
							state_q <= rsa_pkg::ST_USE;
						end
					end
				end
				rsa_pkg::ST_USE: begin
					state_q <= rsa_pkg::ST_READ;
					if (!op_q) begin
						acc_q <= acc_next;
						cnt_q <= cnt_q - 16'h0001;
						half_q <= byte_mode && !half_q;
						if (!byte_mode || half_q) addr_q <= addr_q + 16'h0001;
						if (item_bad) begin
							er_q <= 1'b1;
							state_q <= rsa_pkg::ST_DONE;
						end else if (cnt_q == 16'h0001) begin
							state_q <= rsa_pkg::ST_WRITE;
						end
					end else begin
						addr_q <= addr_q + 16'h0001;
						case (step_q)
							rsa_pkg::STEP_SRC: begin
								x_q <= rd_q;
								step_q <= rsa_pkg::STEP_HDR;
								addr_q <= cw_q;
								if (trig_mode) begin
									cx_r <= rsa_pkg::CORDIC_GAIN;
									cy_r <= 24'sh000000;
									cz_r <= $signed(ang_rad[31:8]);
									it_q <= 6'h00;
									state_q <= ang_ok ? rsa_pkg::ST_CORDIC : rsa_pkg::ST_DONE;
									er_q <= !ang_ok;
								end
							end
							rsa_pkg::STEP_HDR: begin
								hdr_q <= rd_q;
								x_q <= x_conv;
								step_q <= rsa_pkg::STEP_XMAX;
								if (!in_bin && !is_bcd(x_q)) begin
									er_q <= 1'b1;
									state_q <= rsa_pkg::ST_DONE;
								end
							end
							rsa_pkg::STEP_XMAX: begin
								xm_q <= rd_q;
								if (hdr_q[rsa_pkg::HDR_MIRROR_BIT]) x_q <= x_mirror;
								step_q <= rsa_pkg::STEP_Y0;
							end
							rsa_pkg::STEP_Y0: begin
								py_q <= rd_q;
								px_q <= 16'h0000;
								k_q <= 8'h01;
								step_q <= rsa_pkg::STEP_XK;
							end
							rsa_pkg::STEP_XK: begin
								cx_q <= rd_q;
								step_q <= rsa_pkg::STEP_YK;
							end
							rsa_pkg::STEP_YK: begin
								step_q <= rsa_pkg::STEP_XK;
								if (x_q < cx_q) begin
									den_q <= cx_q - px_q;
									num_q <= prod_abs[31:0];
									sgn_q <= prod[33];
									rem_q <= 16'h0000;
									it_q <= 6'h00;
									state_q <= rsa_pkg::ST_DIVIDE;
								end else if (x_q == cx_q || last_seg) begin
									res_q <= cy_fmt;
									state_q <= rsa_pkg::ST_WRITE;
								end else begin
									px_q <= cx_q;
									py_q <= rd_q;
									k_q <= k_q + 8'h01;
								end
							end
							default: begin
								state_q <= rsa_pkg::ST_DONE;
							end
						endcase
					end
				end
				rsa_pkg::ST_CORDIC: begin
					cx_r <= cz_r[23] ? cx_r + ys : cx_r - ys;
					cy_r <= cz_r[23] ? cy_r - xs : cy_r + xs;
					cz_r <= cz_r[23] ? cz_r + atan_i : cz_r - atan_i;
					it_q <= it_q + 6'h01;
					if (it_q == rsa_pkg::CORDIC_ITER) begin
						res_q <= trig_bcd;
						state_q <= rsa_pkg::ST_WRITE;
					end
				end
				rsa_pkg::ST_DIVIDE: begin
					it_q <= it_q + 6'h01;
					if (it_q == rsa_pkg::DIV_ITER) begin
						res_q <= lin_fmt;
						state_q <= rsa_pkg::ST_WRITE;
					end else begin
						rem_q <= dfit ? dsub[15:0] : dtrial[15:0];
						num_q <= {num_q[30:0], dfit};
					end
				end
				rsa_pkg::ST_WRITE: begin
					req_q <= 1'b1;
					we_q <= 1'b1;
					maddr_q <= wr_hi_q ? dst_q + 16'h0001 : dst_q;
					wdata_q <= wr_word;
					state_q <= rsa_pkg::ST_WWAIT;
				end
				rsa_pkg::ST_WWAIT: begin
					if (LINK.mem_ack) begin
						if (LINK.mem_err) begin
							er_q <= 1'b1;
							state_q <= rsa_pkg::ST_DONE;
						end else if (!op_q && !wr_hi_q) begin
							wr_hi_q <= 1'b1;
							state_q <= rsa_pkg::ST_WRITE;
						end else begin
							eq_q <= zero_res;
							neg_q <= low_word[15];
							state_q <= rsa_pkg::ST_DONE;
						end
					end
				end
				rsa_pkg::ST_DONE: begin
					done_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= rsa_pkg::ST_IDLE;
				end
				default: begin
					state_q <= rsa_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign BUSY = busy_q;
	assign LINK.busy = busy_q;
	assign LINK.done = done_q;
	assign LINK.error_flag = er_q;
	assign LINK.equal_zero_flag = eq_q;
	assign LINK.negative_flag = neg_q;
	assign LINK.mem_req = req_q;
	assign LINK.mem_we = we_q;
	assign LINK.mem_addr = maddr_q;
	assign LINK.mem_wdata = wdata_q;
endmodule // rsa_arith_unit

// ==== src/rsa_sequencer.sv ====
module rsa_sequencer (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	rsa_link_if.seq LINK
);
	logic [15:0] mem [0:1023];
	logic pready_q, pslverr_q, req_q, op_q, exec_q, const_q, done_q;
	logic ack_q, err_q;
	logic [31:0] prdata_q;
	logic [15:0] cw_q, src_q, dst_q, rdata_q;
	logic [rsa_pkg::MEM_AW-1:0] maddr_q;

	// ==========================================================
	// APB decode; one wait-free access cycle after setup
	wire setup = PSEL && !PENABLE && !pready_q;
	wire wr_en = PSEL && PENABLE && pready_q && PWRITE;
	wire hit_cmd = PADDR == rsa_pkg::REG_CMD;
	wire hit_cw = PADDR == rsa_pkg::REG_CWORD;
	wire hit_src = PADDR == rsa_pkg::REG_SRC;
	wire hit_dst = PADDR == rsa_pkg::REG_DST;
	wire hit_sts = PADDR == rsa_pkg::REG_STATUS;
	wire hit_ma = PADDR == rsa_pkg::REG_MADDR;
	wire hit_md = PADDR == rsa_pkg::REG_MDATA;
	wire mapped = hit_cmd || hit_cw || hit_src || hit_dst || hit_sts || hit_ma || hit_md;
	// Memory writes from software are refused while the unit owns the memory
	wire refuse = !mapped || (PWRITE && hit_md && LINK.busy);
	wire [31:0] status = {27'h0000000, LINK.negative_flag, LINK.equal_zero_flag,
		LINK.error_flag, done_q, LINK.busy};
	wire [31:0] rd_mux = hit_cmd ? {28'h0000000, const_q, exec_q, op_q, 1'b0} :
		hit_cw ? {16'h0000, cw_q} : hit_src ? {16'h0000, src_q} :
		hit_dst ? {16'h0000, dst_q} : hit_sts ? status :
		hit_ma ? {22'h000000, maddr_q} : hit_md ? {16'h0000, mem[maddr_q]} : 32'h00000000;
	wire start = wr_en && hit_cmd && PWDATA[0] && !LINK.busy;
	wire dev_oob = LINK.mem_addr >= rsa_pkg::MEM_WORDS;
	wire dev_wr = LINK.mem_req && LINK.mem_we && !dev_oob;

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && refuse;
			prdata_q <= (setup && !PWRITE && mapped) ? rd_mux : 32'h00000000;
		end
	end

	// ==========================================================
	// Operand registers and start
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			req_q <= 1'b0;
			op_q <= 1'b0;
			exec_q <= 1'b0;
			const_q <= 1'b0;
			done_q <= 1'b0;
			cw_q <= rsa_pkg::WORD_RESET;
			src_q <= rsa_pkg::WORD_RESET;
			dst_q <= rsa_pkg::WORD_RESET;
			maddr_q <= '0;
		end else begin
			req_q <= start;
			if (wr_en && hit_cmd) begin
				op_q <= PWDATA[1];
				exec_q <= PWDATA[2];
				const_q <= PWDATA[3];
			end
			if (wr_en && hit_cw) cw_q <= PWDATA[15:0];
			if (wr_en && hit_src) src_q <= PWDATA[15:0];
			if (wr_en && hit_dst) dst_q <= PWDATA[15:0];
			if (wr_en && hit_ma) maddr_q <= PWDATA[rsa_pkg::MEM_AW-1:0];
			// Completion is sticky; a new completion wins over a clear
			if (LINK.done) done_q <= 1'b1;
			else if (wr_en && hit_sts && PWDATA[1]) done_q <= 1'b0;
		end
	end

	// ==========================================================
	// Data memory: tables and ranges are laid out by software
	always_ff @(posedge CLOCK) begin
		if (dev_wr) mem[LINK.mem_addr[rsa_pkg::MEM_AW-1:0]] <= LINK.mem_wdata;
		else if (wr_en && hit_md && !LINK.busy) mem[maddr_q] <= PWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= rsa_pkg::WORD_RESET;
		end else begin
			ack_q <= LINK.mem_req;
			err_q <= LINK.mem_req && dev_oob;
			rdata_q <= mem[LINK.mem_addr[rsa_pkg::MEM_AW-1:0]];
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign LINK.req = req_q;
	assign LINK.op_apr = op_q;
	assign LINK.exec_cond = exec_q;
	assign LINK.ctrl_const = const_q;
	assign LINK.ctrl_word = cw_q;
	assign LINK.src_addr = src_q;
	assign LINK.dst_addr = dst_q;
	assign LINK.mem_rdata = rdata_q;
	assign LINK.mem_ack = ack_q;
	assign LINK.mem_err = err_q;
endmodule // rsa_sequencer

// ==== verification/rsa_link_monitor.sv ====
module rsa_link_monitor (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic req,
	input wire logic op_apr,
	input wire logic exec_cond,
	input wire logic ctrl_const,
	input wire logic [15:0] ctrl_word,
	input wire logic busy,
	input wire logic done,
	input wire logic error_flag,
	input wire logic equal_zero_flag,
	input wire logic negative_flag,
	input wire logic mem_req,
	input wire logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// A request only counts as a start while the unit is idle
	wire logic go = req && !busy;
	wire logic [2:0] flags = {error_flag, equal_zero_flag, negative_flag};
	// ==========
	// Link behaviour
	property p_go_busy; go |=> busy; endproperty
	property p_skip_quiet; go && !exec_cond |=> (!mem_req && $stable(flags))[*2]; endproperty
	property p_skip_done; go && !exec_cond |-> ##2 done; endproperty
	property p_bad_count;
		go && exec_cond && !op_apr && ctrl_word[11:0] == 12'h000 |-> ##2 (done && error_flag);
	endproperty
	property p_bad_const;
		go && exec_cond && op_apr && ctrl_const && ctrl_word > 16'h0001 |-> ##2 (done && error_flag);
	endproperty
	property p_done_bound; go |-> ##[2:1000] done; endproperty
	property p_mem_ack; mem_req |=> mem_ack; endproperty
	property p_mem_busy; mem_req |-> busy; endproperty
	property p_done_past; done |-> $past(busy); endproperty
	a_go_busy: assert property (p_go_busy) else $error("busy missing after start");
	a_skip_quiet: assert property (p_skip_quiet) else $error("skipped op acted");
	a_skip_done: assert property (p_skip_done) else $error("skipped op not done");
	a_bad_count: assert property (p_bad_count) else $error("bad count accepted");
	a_bad_const: assert property (p_bad_const) else $error("bad code accepted");
	a_done_bound: assert property (p_done_bound) else $error("op never ends");
	a_mem_ack: assert property (p_mem_ack) else $error("memory answer late");
	a_mem_busy: assert property (p_mem_busy) else $error("memory access idle");
	a_done_past: assert property (p_done_past) else $error("done without busy");
	c_err: cover property (done && error_flag);
	c_eq: cover property (done && equal_zero_flag);
	c_trig: cover property (go && op_apr && ctrl_const);
endmodule // rsa_link_monitor

// ==== verification/range_sum_and_function_approx_unit_tb.sv ====
module range_sum_and_function_approx_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic err_seen;
	logic [31:0] seed = 32'h52;
	int n_mismatch = 0;
	int cmp_count = 0;
	// Control word high nibble: bit15 signed, bit14 binary, bit13 bytes, bit12 skip
	logic [3:0] modes [6] = '{4'h0, 4'h4, 4'hc, 4'h6, 4'h7, 4'hf};
	logic [3:0] ecmd [7] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'hf, 4'hf, 4'h7};
	logic [15:0] ecw [7] = '{16'h1, 16'h0, 16'ha, 16'h4005, 16'h0, 16'h2, 16'h3fe};
	logic [15:0] esrc [7] = '{16'h200, 16'h200, 16'h200, 16'h3fe, 16'h210, 16'h210, 16'h210};
	logic [15:0] tang [5] = '{16'h300, 16'h300, 16'h900, 16'h0, 16'h0};
	logic [15:0] texp [5] = '{16'h5000, 16'h8660, 16'h9999, 16'h9999, 16'h0};
	logic [4:0] tcos = 5'b01010;
	logic [15:0] tbl [6] = '{16'h64, 16'h0, 16'h28, 16'h50, 16'h64, 16'h14};
	logic [15:0] hdr [3] = '{16'hc001, 16'he001, 16'h0001};
	logic [15:0] xin [3] = '{16'ha, 16'ha, 16'h70};
	logic [15:0] fx [3] = '{16'h14, 16'h1e, 16'h50};
	rsa_link_if lnk ();
	rsa_arith_unit rsa_arith_unit_inst (.CLOCK(clock), .NRST(rst_n), .LINK(lnk), .BUSY());
	rsa_sequencer rsa_sequencer_inst (.CLOCK(clock), .NRST(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .LINK(lnk));
	rsa_link_monitor rsa_link_monitor_inst (.CLOCK(clock), .NRST(rst_n), .req(lnk.req),
		.op_apr(lnk.op_apr), .exec_cond(lnk.exec_cond), .ctrl_const(lnk.ctrl_const),
		.ctrl_word(lnk.ctrl_word), .busy(lnk.busy), .done(lnk.done), .error_flag(lnk.error_flag),
		.equal_zero_flag(lnk.equal_zero_flag), .negative_flag(lnk.negative_flag),
		.mem_req(lnk.mem_req), .mem_ack(lnk.mem_ack));
	initial begin
		forever #20 clock = ~clock;
	end
	// ==========
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] rbcd();
		logic [15:0] w;
		for (int i = 0; i < 4; i++) w[4*i+:4] = 4'(rnd() % 10);
		return w;
	endfunction
	function automatic int dec(input logic [15:0] w);
		return 1000 * int'(w[15:12]) + 100 * int'(w[11:8]) + 10 * int'(w[7:4]) + int'(w[3:0]);
	endfunction
	function automatic logic [31:0] to_bcd(input int v);
		logic [31:0] r;
		for (int i = 0; i < 8; i++) begin
			r[4*i+:4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// No local limit: only the watchdog may end a wait for the answer
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		r = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic mw(input logic [15:0] a, input logic [15:0] d);
		logic [31:0] r;
		apb(1'b1, rsa_pkg::REG_MADDR, 32'(a), r);
		apb(1'b1, rsa_pkg::REG_MDATA, 32'(d), r);
	endtask
	task automatic mr(input logic [15:0] a, output logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, rsa_pkg::REG_MADDR, 32'(a), r);
		apb(1'b0, rsa_pkg::REG_MDATA, 32'h0, d);
	endtask
	// Destination is always set to 0x100; polling has no local limit, only the watchdog bounds the wait
	task automatic run(input logic [3:0] c, input logic [15:0] cw, input logic [15:0] s,
		output logic [31:0] st);
		logic [31:0] r;
		apb(1'b1, rsa_pkg::REG_CWORD, 32'(cw), r);
		apb(1'b1, rsa_pkg::REG_SRC, 32'(s), r);
		apb(1'b1, rsa_pkg::REG_DST, 32'h100, r);
		apb(1'b1, rsa_pkg::REG_CMD, 32'(c), r);
		st = 32'h0;
		while (st[1] !== 1'b1) begin
			apb(1'b0, rsa_pkg::REG_STATUS, 32'h0, st);
		end
		apb(1'b1, rsa_pkg::REG_STATUS, 32'h2, r);
	endtask
	task automatic chk_res(input logic [31:0] e, input logic two, input logic [31:0] st);
		logic [31:0] lo;
		logic [31:0] hi;
		hi = 32'h0;
		mr(16'h100, lo);
		if (two) mr(16'h101, hi);
		chk("result", e, {hi[15:0], lo[15:0]});
		chk("error", 32'h0, 32'(st[2]));
		chk("equal", 32'(e == 0), 32'(st[3]));
		chk("negative", 32'(e[15]), 32'(st[4]));
		chk("busy", 32'h0, 32'(st[0]));
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clock);
		n_mismatch++;
		finish_test();
	end
	// ==========
	// Scenarios
	initial begin
		logic [31:0] st;
		logic [31:0] v;
		logic [15:0] img [10];
		logic [7:0] b;
		int n;
		int j;
		int acc;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, 8'h20, 32'h0, v);
		chk("unmapped", 32'h1, 32'(err_seen));
		for (int m = 0; m < 6; m++) begin
			n = 1 + int'(rnd() % 9);
			for (int k = 0; k < 10; k++) begin
				img[k] = (m == 0) ? rbcd() : 16'(rnd());
				mw(16'h200 + 16'(k), img[k]);
			end
			acc = 0;
			for (int k = 0; k < n; k++) begin
				j = k + int'(modes[m][0]);
				b = j[0] ? img[j / 2][7:0] : img[j / 2][15:8];
				if (modes[m][1]) acc += modes[m][3] ? int'($signed(b)) : int'(b);
				else if (modes[m][2]) acc += modes[m][3] ? int'($signed(img[k])) : int'(img[k]);
				else acc += dec(img[k]);
			end
			run(4'h5, {modes[m], 8'h00, 4'(n)}, 16'h200, st);
			chk_res(modes[m][2] ? 32'(acc) : to_bcd(acc), 1'b1, st);
		end
		for (int i = 0; i < 5; i++) begin
			mw(16'h210, tang[i]);
			run(4'hf, {15'h0, tcos[i]}, 16'h210, st);
			chk_res(32'(texp[i]), 1'b0, st);
		end
		for (int i = 0; i < 6; i++) mw(16'h301 + 16'(i), tbl[i]);
		for (int i = 0; i < 3; i++) begin
			mw(16'h300, hdr[i]);
			mw(16'h210, xin[i]);
			run(4'h7, 16'h300, 16'h210, st);
			chk_res(32'(fx[i]), 1'b0, st);
		end
		mw(16'h200, 16'ha0);
		mw(16'h3fe, 16'hc005);
		mw(16'h3ff, 16'hff);
		mw(16'h210, 16'h901);
		for (int i = 0; i < 7; i++) begin
			run(ecmd[i], ecw[i], esrc[i], st);
			chk("error flag", 32'h1, 32'(st[2]));
		end
		mw(16'h100, 16'h1234);
		v = st;
		run(4'h1, 16'h4001, 16'h200, st);
		chk("kept flags", 32'(v[4:2]), 32'(st[4:2]));
		mr(16'h100, v);
		chk("kept word", 32'h1234, v);
		finish_test();
	end
endmodule // range_sum_and_function_approx_unit_tb
